//--- common/psmc_pkg.sv
// package for the power saving mode controller
package psmc_pkg;

  // ************************************************************
  // operand codes of the power save instruction
  // ************************************************************
  localparam logic [0:0] OP_SLEEP = 1'h0;
  localparam logic [0:0] OP_IDLE = 1'h1;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 50;
  localparam int RET_RECOVERY_US = 35;
  localparam int RET_RECOVERY_CYC = RET_RECOVERY_US * CLK_MHZ;
  localparam int FAST_SAVE_US = 10;
  localparam int FAST_SAVE_CYC = FAST_SAVE_US * CLK_MHZ;
  localparam int RECOVERY_W = 12;
  localparam logic [1:0] LOCK_PER_RUNNING = 2'h1;
  localparam logic [1:0] LOCK_PER_STOPPED = 2'h2;
  localparam logic [2:0] SLOW_RATIO_RESET = 3'h0;

  // ************************************************************
  // sleep variant encoding {retention_enable, fast_wake_regulator}
  // ************************************************************
  localparam logic [1:0] VAR_PLAIN = 2'h0;
  localparam logic [1:0] VAR_FAST = 2'h1;
  localparam logic [1:0] VAR_RET = 2'h2;
  localparam logic [1:0] VAR_FAST_RET = 2'h3;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    PSMC_RUN = 3'h0,
    PSMC_ENTER = 3'h1,
    PSMC_SLEEP = 3'h3,
    PSMC_WAKE = 3'h2,
    PSMC_IDLE = 3'h6
  } psmc_state_type;

  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic osc_en;
    logic periph_clk_en;
    logic low_power_rc_clock_en;
    logic fail_safe_clock_monitor_active;
    logic wdt_clear;
    logic retention_reg_en;
    logic bandgap_en;
  } psmc_ctrl_type;

endpackage : psmc_pkg

//--- rtl/psmc_lockout.sv
// lockout timer counting low power rc clock edges in retention sleep
`timescale 1ns/1ps
module psmc_lockout (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic active,
  input wire logic low_power_rc_clock_was_running,
  input wire logic low_power_rc_clock_ready,
  input wire logic low_power_rc_clock_edge,
  output logic expired
);

  logic [1:0] need_r;
  logic [1:0] seen_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      need_r <= 2'h0;
      seen_r <= 2'h0;
      expired <= 1'b0;
    end else if (start) begin
      need_r <= low_power_rc_clock_was_running ? psmc_pkg::LOCK_PER_RUNNING : psmc_pkg::LOCK_PER_STOPPED;
      seen_r <= 2'h0;
      expired <= 1'b0;
    end else if (!active) begin
      expired <= 1'b0;
    end else if (!expired && low_power_rc_clock_ready && low_power_rc_clock_edge) begin
      seen_r <= seen_r + 2'h1;
      if (seen_r + 2'h1 >= need_r) begin
        expired <= 1'b1;
      end
    end
  end

endmodule : psmc_lockout

//--- rtl/psmc_top.sv
// power saving mode controller: sleep, idle, retention lockout, slowed cpu
`timescale 1ns/1ps
module psmc_top #(
  parameter int RET_RECOVERY = psmc_pkg::RET_RECOVERY_CYC,
  parameter int FAST_SAVE = psmc_pkg::FAST_SAVE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_save_instruction,
  input wire logic power_save_operand,
  input wire logic irq_pending,
  input wire logic other_reset,
  input wire logic power_on_reset,
  input wire logic master_clear_pin,
  input wire logic wdt_timeout,
  input wire logic wdt_enable,
  input wire logic fail_safe_clock_monitor,
  input wire logic retention_config_bit,
  input wire logic retention_enable,
  input wire logic fast_wake_regulator,
  input wire logic low_power_rc_running,
  input wire logic low_power_rc_ready,
  input wire logic low_power_rc_edge,
  input wire logic cpu_slowdown_enable,
  input wire logic [2:0] slow_ratio,
  input wire logic restore_on_interrupt,
  input wire logic clock_locked,
  input wire logic new_osc_write,
  input wire logic [2:0] new_oscillator_select,
  output psmc_pkg::psmc_ctrl_type ctrl,
  output logic low_power_rc_clock,
  output logic cpu_clk_tick,
  output logic slowdown_active,
  output logic clk_switch_req,
  output logic [2:0] clk_switch_sel,
  output logic [2:0] resume_clk_sel,
  output logic lockout_active,
  output logic [1:0] sleep_variant,
  output logic in_sleep,
  output logic in_idle,
  output logic cpu_resume
);

  // ************************************************************
  // state
  // ************************************************************
  psmc_pkg::psmc_state_type state_r;
  logic op_r;
  logic ret_r;
  logic lock_start_r;
  logic lock_expired;
  logic [psmc_pkg::RECOVERY_W-1:0] rec_r;
  logic [2:0] cur_clk_r;
  logic irq_armed_r;
  logic wake_src;
  logic ret_ok;
  logic [1:0] variant;
  logic [psmc_pkg::RECOVERY_W-1:0] rec_len;

  assign variant = {retention_enable, fast_wake_regulator};
  assign ret_ok = !retention_config_bit && retention_enable;
  assign rec_len = (variant == psmc_pkg::VAR_RET) ? RET_RECOVERY[psmc_pkg::RECOVERY_W-1:0] :
    (variant == psmc_pkg::VAR_FAST_RET) ? 
      psmc_pkg::RECOVERY_W'(RET_RECOVERY - FAST_SAVE) :
    psmc_pkg::RECOVERY_W'(1);

  // interrupt wake requires a fresh interrupt after lockout in retention
  always_comb begin
    if (ret_r && state_r == psmc_pkg::PSMC_SLEEP && !lock_expired) begin
      wake_src = power_on_reset || master_clear_pin;
    end else if (ret_r && state_r == psmc_pkg::PSMC_SLEEP) begin
      wake_src = (irq_pending && irq_armed_r) || other_reset || power_on_reset ||
        master_clear_pin || wdt_timeout;
    end else begin
      wake_src = irq_pending || other_reset || power_on_reset || master_clear_pin ||
        wdt_timeout;
    end
  end

  // an interrupt seen during lockout must drop before it can wake
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_armed_r <= 1'b0;
    end else if (state_r != psmc_pkg::PSMC_SLEEP || !lock_expired) begin
      irq_armed_r <= 1'b0;
    end else if (!irq_pending) begin
      irq_armed_r <= 1'b1;
    end
  end

  // ************************************************************
  // mode state machine
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= psmc_pkg::PSMC_RUN;
      op_r <= 1'b0;
      ret_r <= 1'b0;
      lock_start_r <= 1'b0;
      rec_r <= '0;
    end else begin
      lock_start_r <= 1'b0;
      unique case (state_r)
        psmc_pkg::PSMC_RUN: begin
          if (power_save_instruction) begin
            op_r <= power_save_operand;
            state_r <= psmc_pkg::PSMC_ENTER;
          end
        end
        psmc_pkg::PSMC_ENTER: begin
          // interrupts ignored here; they wake on the next state unless it is retention sleep
          if (op_r == psmc_pkg::OP_SLEEP) begin
            state_r <= psmc_pkg::PSMC_SLEEP;
            ret_r <= ret_ok;
            lock_start_r <= ret_ok;
            rec_r <= ret_ok ? rec_len : psmc_pkg::RECOVERY_W'(1);
          end else begin
            state_r <= psmc_pkg::PSMC_IDLE;
          end
        end
        psmc_pkg::PSMC_SLEEP: begin
          if (wake_src && !lock_start_r) begin
            state_r <= psmc_pkg::PSMC_WAKE;
          end
        end
        psmc_pkg::PSMC_WAKE: begin
          if (rec_r <= psmc_pkg::RECOVERY_W'(1)) begin
            state_r <= psmc_pkg::PSMC_RUN;
            ret_r <= 1'b0;
          end else begin
            rec_r <= rec_r - psmc_pkg::RECOVERY_W'(1);
          end
        end
        psmc_pkg::PSMC_IDLE: begin
          if (wake_src) begin
            state_r <= psmc_pkg::PSMC_RUN;
          end
        end
        default: state_r <= psmc_pkg::PSMC_RUN;
      endcase
    end
  end

  psmc_lockout u_lockout (
    .clk(clk),
    .nrst(nrst),
    .start(lock_start_r),
    .active(ret_r),
    .low_power_rc_clock_was_running(low_power_rc_running),
    .low_power_rc_clock_ready(low_power_rc_ready),
    .low_power_rc_clock_edge(low_power_rc_edge),
    .expired(lock_expired)
  );

  // ************************************************************
  // clock source tracking and switch request
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur_clk_r <= 3'h0;
      clk_switch_req <= 1'b0;
      clk_switch_sel <= 3'h0;
    end else begin
      clk_switch_req <= new_osc_write && !clock_locked;
      if (new_osc_write && !clock_locked) begin
        clk_switch_sel <= new_oscillator_select;
        cur_clk_r <= new_oscillator_select;
      end
    end
  end

  // ************************************************************
  // slowed cpu clock divider
  // ************************************************************
  logic [7:0] div_r;
  logic slow_r;
  logic [7:0] div_max;
  assign div_max = 8'((9'h1 << slow_ratio) - 9'h1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slow_r <= 1'b0;
    end else if (!cpu_slowdown_enable) begin
      slow_r <= 1'b0;
    end else if (irq_pending && restore_on_interrupt) begin
      slow_r <= 1'b0;
    end else if (!irq_pending || !restore_on_interrupt) begin
      slow_r <= slow_r || !irq_pending || !restore_on_interrupt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 8'h0;
      cpu_clk_tick <= 1'b0;
    end else if (!slow_r || div_r >= div_max) begin
      div_r <= 8'h0;
      cpu_clk_tick <= 1'b1;
    end else begin
      div_r <= div_r + 8'h1;
      cpu_clk_tick <= 1'b0;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  logic sleep_n;
  logic idle_n;
  assign sleep_n = state_r == psmc_pkg::PSMC_SLEEP;
  assign idle_n = state_r == psmc_pkg::PSMC_IDLE;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= '{cpu_clk_en: 1'b1, sys_clk_en: 1'b1, osc_en: 1'b1, periph_clk_en: 1'b1,
        low_power_rc_clock_en: 1'b0, fail_safe_clock_monitor_active: 1'b0, wdt_clear: 1'b0, retention_reg_en: 1'b0,
        bandgap_en: 1'b1};
      low_power_rc_clock <= 1'b0;
      slowdown_active <= 1'b0;
      resume_clk_sel <= 3'h0;
      lockout_active <= 1'b0;
      sleep_variant <= psmc_pkg::VAR_PLAIN;
      in_sleep <= 1'b0;
      in_idle <= 1'b0;
      cpu_resume <= 1'b0;
    end else begin
      ctrl.cpu_clk_en <= !sleep_n && !idle_n;
      ctrl.sys_clk_en <= !sleep_n;
      ctrl.osc_en <= !sleep_n;
      ctrl.periph_clk_en <= !sleep_n;
      ctrl.fail_safe_clock_monitor_active <= fail_safe_clock_monitor && !sleep_n;
      ctrl.low_power_rc_clock_en <= sleep_n ? wdt_enable :
        (wdt_enable || fail_safe_clock_monitor);
      ctrl.wdt_clear <= wdt_enable && state_r == psmc_pkg::PSMC_ENTER;
      ctrl.retention_reg_en <= sleep_n && ret_r;
      ctrl.bandgap_en <= !sleep_n || fast_wake_regulator;
      low_power_rc_clock <= sleep_n ? wdt_enable : (wdt_enable || fail_safe_clock_monitor);
      slowdown_active <= slow_r;
      if (state_r == psmc_pkg::PSMC_ENTER) begin
        resume_clk_sel <= cur_clk_r;
      end
      lockout_active <= sleep_n && ret_r && !lock_expired;
      sleep_variant <= variant;
      in_sleep <= sleep_n;
      in_idle <= idle_n;
      cpu_resume <= (state_r == psmc_pkg::PSMC_WAKE && rec_r <= psmc_pkg::RECOVERY_W'(1)) ||
        (idle_n && wake_src);
    end
  end

endmodule : psmc_top

//--- sim/psmc_properties.sv
// assertion checker for the power saving mode controller
`timescale 1ns/1ps
module psmc_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_save_instruction,
  input wire logic power_save_operand,
  input wire logic irq_pending,
  input wire logic wdt_enable,
  input wire logic fail_safe_clock_monitor,
  input wire logic retention_config_bit,
  input wire logic retention_enable,
  input wire logic fast_wake_regulator,
  input wire logic power_on_reset,
  input wire logic master_clear_pin,
  input wire logic clock_locked,
  input wire logic new_osc_write,
  input wire logic [2:0] new_oscillator_select,
  input wire psmc_pkg::psmc_ctrl_type ctrl,
  input wire logic clk_switch_req,
  input wire logic [2:0] clk_switch_sel,
  input wire logic lockout_active,
  input wire logic [1:0] sleep_variant,
  input wire logic in_sleep,
  input wire logic in_idle,
  input wire logic cpu_resume
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ************************************************************
  // entry sequences
  // ************************************************************
  sequence run_req;
    power_save_instruction && !in_idle && !in_sleep && !irq_pending;
  endsequence
  sequence idle_req;
    run_req ##0 power_save_operand;
  endsequence
  sequence sleep_req;
    run_req ##0 !power_save_operand;
  endsequence
  // ************************************************************
  // properties
  // ************************************************************
  idle_entry_a: assert property (idle_req |-> ##3 in_idle)
    else $error("idle not entered");
  sleep_entry_a: assert property (sleep_req |-> ##3 in_sleep)
    else $error("sleep not entered");
  sleep_clocks_a: assert property (in_sleep |-> !ctrl.sys_clk_en && !ctrl.osc_en &&
    !ctrl.periph_clk_en && !ctrl.fail_safe_clock_monitor_active) else $error("clocks run in sleep");
  sleep_rc_a: assert property (in_sleep && wdt_enable |-> ctrl.low_power_rc_clock_en)
    else $error("rc stopped in sleep");
  wdt_clear_a: assert property (run_req ##0 wdt_enable |-> ##[1:2] ctrl.wdt_clear)
    else $error("watchdog not cleared");
  idle_clocks_a: assert property (in_idle |-> !ctrl.cpu_clk_en && ctrl.sys_clk_en &&
    ctrl.periph_clk_en) else $error("idle clocks wrong");
  idle_rc_a: assert property (in_idle && (wdt_enable || fail_safe_clock_monitor)
    |-> ctrl.low_power_rc_clock_en) else $error("rc stopped in idle");
  idle_wake_a: assert property (in_idle && irq_pending |-> ##[0:1] cpu_resume)
    else $error("idle wake missing");
  ret_reg_a: assert property (ctrl.retention_reg_en |-> !in_idle && retention_enable &&
    !retention_config_bit) else $error("retention regulator misused");
  sleep_mode_a: assert property (in_sleep |->
    sleep_variant == {retention_enable, fast_wake_regulator}) else $error("variant wrong");
  lockout_mask_a: assert property (lockout_active && irq_pending && !master_clear_pin &&
    !power_on_reset |=> !cpu_resume) else $error("lockout not masking");
  osc_switch_a: assert property (new_osc_write && !clock_locked |=> clk_switch_req &&
    clk_switch_sel == $past(new_oscillator_select)) else $error("switch request wrong");
endmodule : psmc_properties

bind psmc_top psmc_properties u_psmc_properties (.*);

//--- sim/psmc_rc_model.sv
// low power rc oscillator model feeding the lockout timer
`timescale 1ns/1ps
module psmc_rc_model #(
  parameter int PERIOD = 100,
  parameter int WAKEUP = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rc_enable,
  output logic rc_ready,
  output logic rc_edge
);
  int cnt;
  // start-up delay, then one edge per period; stops when disabled
  always @(posedge clk or negedge nrst) begin
    if (!nrst || !rc_enable) begin
      cnt <= 0;
      rc_ready <= 1'b0;
      rc_edge <= 1'b0;
    end else begin
      cnt <= (cnt == WAKEUP + PERIOD - 1) ? WAKEUP : cnt + 1;
      rc_ready <= (cnt >= WAKEUP);
      rc_edge <= (cnt == WAKEUP + PERIOD - 1);
    end
  end
endmodule : psmc_rc_model

//--- sim/psmc_top_tb.sv
// self-checking bench for the power saving mode controller
`timescale 1ns/1ps
module psmc_top_tb;
  localparam int RET = 20;
  localparam int FST = 5;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic power_save_instruction = 0, power_save_operand = 0, irq_pending = 0;
  logic other_reset = 0, power_on_reset = 0, master_clear_pin = 0, wdt_timeout = 0;
  logic wdt_enable = 1, fail_safe_clock_monitor = 0, retention_config_bit = 0;
  logic retention_enable = 0, fast_wake_regulator = 0, cpu_slowdown_enable = 0;
  logic restore_on_interrupt = 0, clock_locked = 0, new_osc_write = 0;
  logic [2:0] slow_ratio = 3'h0, new_oscillator_select = 3'h0;
  logic low_power_rc_ready, low_power_rc_edge, low_power_rc_clock, cpu_clk_tick;
  logic slowdown_active, clk_switch_req, lockout_active, in_sleep, in_idle, cpu_resume;
  logic [2:0] clk_switch_sel, resume_clk_sel;
  logic [1:0] sleep_variant;
  psmc_pkg::psmc_ctrl_type ctrl;
  int n_mismatch = 0, checks_done = 0, n, k, v, rec;
  always #10 clk = ~clk;
  psmc_top #(.RET_RECOVERY(RET), .FAST_SAVE(FST)) u_psmc_top (.*,
    .low_power_rc_running(low_power_rc_ready));
  psmc_rc_model u_psmc_rc_model (.clk(clk), .nrst(nrst), .rc_enable(low_power_rc_clock),
    .rc_ready(low_power_rc_ready), .rc_edge(low_power_rc_edge));
  // ************************************************************
  // tasks
  // ************************************************************
  task stop_test;
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wait_for(input int sel, output int cnt);
    cnt = 0;
    while (!(sel == 0 ? in_idle === 1'b1 : sel == 1 ? in_sleep === 1'b1 :
        sel == 2 ? cpu_resume === 1'b1 : sel == 3 ? lockout_active === 1'b0 :
        low_power_rc_edge === 1'b1)) begin
      @(negedge clk);
      cnt++;
      if (cnt > 400) begin
        n_mismatch++;
        stop_test();
      end
    end
  endtask : wait_for
  task enter(input logic op);
    @(negedge clk);
    power_save_instruction = 1'b1;
    power_save_operand = op;
    @(negedge clk);
    power_save_instruction = 1'b0;
  endtask : enter
  task ticks(input int m, output int cnt);
    cnt = 0;
    repeat (m) begin
      @(negedge clk);
      cnt += (cpu_clk_tick === 1'b1);
    end
  endtask : ticks
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (12) @(negedge clk);
    chk("reset ctrl", ctrl, 9'h1e1);
    nrst = 1'b1;
    @(negedge clk);
    new_oscillator_select = 3'h5;
    new_osc_write = 1'b1;
    @(negedge clk);
    new_osc_write = 1'b0;
    chk("switch sel", clk_switch_sel, 9'h005);
    clock_locked = 1'b1;
    new_oscillator_select = 3'h2;
    new_osc_write = 1'b1;
    @(negedge clk);
    new_osc_write = 1'b0;
    clock_locked = 1'b0;
    chk("locked sel", clk_switch_sel, 9'h005);
    for (k = 0; k < 2; k++) begin
      wdt_enable = !k;
      fail_safe_clock_monitor = k;
      irq_pending = k;
      enter(1'b1);
      wait_for(0, n);
      chk("idle ctrl", {ctrl.cpu_clk_en, ctrl.periph_clk_en, ctrl.low_power_rc_clock_en}, 9'h3);
      wdt_timeout = !k;
      wait_for(2, n);
      chk("idle wake", n < 3, 9'h1);
      wdt_timeout = 1'b0;
      irq_pending = 1'b0;
    end
    wdt_enable = 1'b1;
    fail_safe_clock_monitor = 1'b0;
    for (v = 0; v < 4; v++) begin
      {retention_enable, fast_wake_regulator} = v[1:0];
      wait_for(4, n);
      enter(1'b0);
      wait_for(1, n);
      chk("variant", sleep_variant, v);
      chk("ret reg", {ctrl.retention_reg_en, lockout_active}, {2{v[1]}});
      if (v[1]) begin
        irq_pending = 1'b1;
        repeat (3) @(negedge clk);
        irq_pending = 1'b0;
        chk("masked", in_sleep, 9'h1);
        wait_for(3, n);
        chk("lockout len", n > 80 && n < 100, 9'h1);
      end
      other_reset = (v == 0);
      master_clear_pin = (v == 2);
      irq_pending = v[0];
      rec = (v == 2) ? RET : (v == 3) ? RET - FST : 0;
      wait_for(2, n);
      chk("recovery", n >= rec && n < rec + 8, 9'h1);
      chk("resume clk", resume_clk_sel, 9'h005);
      other_reset = 1'b0;
      master_clear_pin = 1'b0;
      irq_pending = 1'b0;
    end
    cpu_slowdown_enable = 1'b1;
    for (k = 0; k < 8; k++) begin
      slow_ratio = k;
      repeat (256) @(negedge clk);
      ticks(256, n);
      chk("ticks", n, 256 >> k);
      chk("slow", {slowdown_active, ctrl.periph_clk_en}, 9'h3);
    end
    slow_ratio = 3'h3;
    for (k = 0; k < 2; k++) begin
      restore_on_interrupt = k;
      irq_pending = 1'b1;
      repeat (8) @(negedge clk);
      ticks(64, n);
      chk("restore", n, k ? 64 : 8);
      irq_pending = 1'b0;
    end
    stop_test();
  end
endmodule : psmc_top_tb
